// >>> design/pim_defines.vh
// Register offsets, field positions, reset values and codes of the input mixing path
`ifndef PIM_DEFINES_VH
`define PIM_DEFINES_VH
`define PIM_ADDR_CTRL 8'h00
`define PIM_ADDR_DAC 8'h04
`define PIM_ADDR_INOFS 8'h08
`define PIM_ADDR_OUTOFS 8'h18
`define PIM_ADDR_COEF 8'h28
`define PIM_ADDR_COEF_LAST 8'h44
`define PIM_ADDR_STATUS 8'h48
`define PIM_CTRL_INSW_LSB 0
`define PIM_CTRL_OUTSW_LSB 4
`define PIM_CTRL_MON_LSB 8
`define PIM_ST_LEVEL_LSB 0
`define PIM_ST_FULL_BIT 5
`define PIM_ST_EMPTY_BIT 6
`define PIM_ST_SAT_LSB 8
`define PIM_CTRL_RST 12'h000
`define PIM_DAC_RST 8'h00
`define PIM_OFS_RST 16'h0000
`define PIM_COEF_ONE 16'h000A
`define PIM_COEF_ZERO 16'h0000
`define PIM_COEF_MAX 16'h00C8
`define PIM_COEF_COARSE 16'h0064
`define PIM_COEF_STEP 16'h000A
`define PIM_COEF_DIV 40'h000000000A
`define PIM_DAC_OFF 2'h0
`define PIM_DAC_0DB 2'h1
`define PIM_DAC_14DB 2'h2
`define PIM_GAIN_14DB 40'h0000000005
`endif

// >>> design/pim_fifo.v
// Sample FIFO between the input converters and the mixing stage
`timescale 1ns/100ps
`default_nettype none
module pim_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire wr_valid_in,
	output wire wr_ready_out,
	input wire [WIDTH-1:0] wr_data_in,
	output wire rd_valid_out,
	input wire rd_ready_in,
	output wire [WIDTH-1:0] rd_data_out,
	output wire [AW:0] count_out
);
	localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	// Handshakes; full and empty come straight from the fill count
	assign wr_ready_out = (count != FULL_COUNT);
	assign rd_valid_out = (count != {(AW+1){1'b0}});
	assign push = wr_valid_in && wr_ready_out && ce_in;
	assign pop = rd_valid_out && rd_ready_in && ce_in;
	assign rd_data_out = mem[rd_ptr];
	assign count_out = count;

	// Storage array, written only on an accepted word
	always @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

	// Pointers and level; depth must be a power of two for the wrap
	always @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (ce_in) begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // pim_fifo
`default_nettype wire

// >>> design/pim_group.v
// One group: input switches and offsets, then the 2x2 mixing matrix
`timescale 1ns/100ps
`default_nettype none
`include "pim_defines.vh"
module pim_group #(
	parameter W = 16
) (
	input wire clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire adv_in,
	input wire signed [W-1:0] first_input_in,
	input wire signed [W-1:0] second_input_in,
	input wire [1:0] in_sw_in,
	input wire signed [15:0] ofs0_in,
	input wire signed [15:0] ofs1_in,
	input wire signed [15:0] coef_a_in,
	input wire signed [15:0] coef_b_in,
	input wire signed [15:0] coef_c_in,
	input wire signed [15:0] coef_d_in,
	output reg signed [W-1:0] upper_mix_path_out,
	output reg signed [W-1:0] lower_mix_path_out,
	output reg [1:0] sat_out
);
	localparam signed [39:0] PMAX = (40'h1 << (W-1)) - 40'h1;
	localparam signed [39:0] NMIN = -PMAX - 40'h1;
	localparam signed [39:0] DIV = `PIM_COEF_DIV;
	wire signed [39:0] sw0;
	wire signed [39:0] sw1;
	wire signed [39:0] off0;
	wire signed [39:0] off1;
	wire signed [39:0] in0;
	wire signed [39:0] in1;
	wire signed [39:0] up_raw;
	wire signed [39:0] lo_raw;
	wire signed [39:0] up_sat;
	wire signed [39:0] lo_sat;

	// Clamp to the datapath full scale
	function signed [39:0] sat;
		input signed [39:0] v;
		begin
			if (v > PMAX) begin
				sat = PMAX;
			end else if (v < NMIN) begin
				sat = NMIN;
			end else begin
				sat = v;
			end
		end
	endfunction

	// Open switch forces zero, closed passes; then offset with clamp
	assign sw0 = in_sw_in[0] ? first_input_in : $signed(40'h0);
	assign sw1 = in_sw_in[1] ? second_input_in : $signed(40'h0);
	assign off0 = sw0 + ofs0_in;
	assign off1 = sw1 + ofs1_in;
	assign in0 = sat(off0);
	assign in1 = sat(off1);
	// Coefficients are in tenths, so the sum is scaled back by ten
	assign up_raw = (in0 * coef_a_in + in1 * coef_b_in) / DIV;
	assign lo_raw = (in0 * coef_c_in + in1 * coef_d_in) / DIV;
	assign up_sat = sat(up_raw);
	assign lo_sat = sat(lo_raw);

	// Mixed paths registered once per accepted sample
	always @(posedge clk_in) begin
		if (rst_in) begin
			upper_mix_path_out <= {W{1'b0}};
			lower_mix_path_out <= {W{1'b0}};
			sat_out <= 2'h0;
		end else if (ce_in && adv_in) begin
			upper_mix_path_out <= up_sat[W-1:0];
			lower_mix_path_out <= lo_sat[W-1:0];
			sat_out[0] <= (up_raw != up_sat);
			sat_out[1] <= (lo_raw != lo_sat);
		end else if (ce_in) begin
			sat_out <= 2'h0;
		end
	end
endmodule // pim_group
`default_nettype wire

// >>> design/pim_path.v
// Top of the PID input mixing signal path: registers, FIFO, groups, output stages
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pim_defines.vh"
module pim_path #(
	parameter W = 16,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire mclk_in,
	input wire rst_in,
	input wire ce_in,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	input wire signed [W-1:0] in0_in,
	input wire signed [W-1:0] in1_in,
	input wire signed [W-1:0] in2_in,
	input wire signed [W-1:0] in3_in,
	input wire in_valid_in,
	output wire in_ready_out,
	output wire signed [W-1:0] mix0_out,
	output wire signed [W-1:0] mix1_out,
	output wire signed [W-1:0] mix2_out,
	output wire signed [W-1:0] mix3_out,
	output reg mix_valid_out,
	input wire mix_ready_in,
	input wire signed [W-1:0] pid0_in,
	input wire signed [W-1:0] pid1_in,
	input wire signed [W-1:0] pid2_in,
	input wire signed [W-1:0] pid3_in,
	input wire pid_valid_in,
	output wire signed [W-1:0] dac0_out,
	output wire signed [W-1:0] dac1_out,
	output wire signed [W-1:0] dac2_out,
	output wire signed [W-1:0] dac3_out,
	output wire [3:0] dac_en_out,
	output reg dac_valid_out,
	output wire signed [W-1:0] mon0_out,
	output wire signed [W-1:0] mon1_out,
	output wire signed [W-1:0] mon2_out,
	output wire signed [W-1:0] mon3_out,
	output reg [3:0] mon_valid_out
);
	localparam signed [39:0] PMAX = (40'h1 << (W-1)) - 40'h1;
	localparam signed [39:0] NMIN = -PMAX - 40'h1;
	localparam signed [39:0] GAIN14 = `PIM_GAIN_14DB;

	reg [11:0] ctrl;
	reg [7:0] dac_mode;
	reg [15:0] in_ofs [0:3];
	reg [15:0] out_ofs [0:3];
	reg [15:0] coef [0:7];
	reg [3:0] sat_sticky;
	reg [31:0] next_rdata;
	wire [4*W-1:0] fifo_wdata;
	wire [4*W-1:0] fifo_rdata;
	wire fifo_valid;
	wire [FIFO_AW:0] fifo_count;
	wire adv;
	wire [3:0] sat_pulse;
	wire [4*W-1:0] mix_bus;
	wire [4*W-1:0] pid_bus;
	wire [4*W-1:0] dac_bus;
	wire [4*W-1:0] mon_bus;
	wire [7:0] word_idx;
	wire aligned;
	wire [31:0] level_ext;
	integer k;

	// Snap a written coefficient onto the legal grid
	function [15:0] coef_fix;
		input [15:0] v;
		reg signed [15:0] s;
		reg [15:0] m;
		begin
			s = v;
			if (s > $signed(`PIM_COEF_MAX)) begin
				s = `PIM_COEF_MAX;
			end else if (s < -$signed(`PIM_COEF_MAX)) begin
				s = -$signed(`PIM_COEF_MAX);
			end
			m = (s < 0) ? -s : s;
			if (m >= `PIM_COEF_COARSE) begin
				m = m - (m % `PIM_COEF_STEP);
			end
			coef_fix = (s < 0) ? -m : m;
		end
	endfunction

	// Clamp to the datapath full scale
	function signed [39:0] sat;
		input signed [39:0] v;
		begin
			if (v > PMAX) begin
				sat = PMAX;
			end else if (v < NMIN) begin
				sat = NMIN;
			end else begin
				sat = v;
			end
		end
	endfunction

	// Incoming samples are buffered; a full FIFO stalls the converters
	assign fifo_wdata = {in3_in, in2_in, in1_in, in0_in};

	pim_fifo #(
		.WIDTH(4*W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_in(mclk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.wr_valid_in(in_valid_in),
		.wr_ready_out(in_ready_out),
		.wr_data_in(fifo_wdata),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(adv),
		.rd_data_out(fifo_rdata),
		.count_out(fifo_count)
	);

	// A sample moves into the mixer when the PID side can take it
	assign adv = fifo_valid && (!mix_valid_out || mix_ready_in);

	always @(posedge mclk_in) begin
		if (rst_in) begin
			mix_valid_out <= 1'b0;
		end else if (ce_in) begin
			if (adv) begin
				mix_valid_out <= 1'b1;
			end else if (mix_ready_in) begin
				mix_valid_out <= 1'b0;
			end
		end
	end

	// Two identical groups, each with its own matrix
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : grp
			pim_group #(
				.W(W)
			) u_group (
				.clk_in(mclk_in),
				.rst_in(rst_in),
				.ce_in(ce_in),
				.adv_in(adv),
				.first_input_in(fifo_rdata[2*g*W +: W]),
				.second_input_in(fifo_rdata[(2*g+1)*W +: W]),
				.in_sw_in(ctrl[`PIM_CTRL_INSW_LSB+2*g +: 2]),
				.ofs0_in(in_ofs[2*g]),
				.ofs1_in(in_ofs[2*g+1]),
				.coef_a_in(coef[4*g]),
				.coef_b_in(coef[4*g+1]),
				.coef_c_in(coef[4*g+2]),
				.coef_d_in(coef[4*g+3]),
				.upper_mix_path_out(mix_bus[2*g*W +: W]),
				.lower_mix_path_out(mix_bus[(2*g+1)*W +: W]),
				.sat_out(sat_pulse[2*g +: 2])
			);
		end
	endgenerate

	// Upper path goes to the first PID of a group, lower to the second
	assign mix0_out = mix_bus[0 +: W];
	assign mix1_out = mix_bus[W +: W];
	assign mix2_out = mix_bus[2*W +: W];
	assign mix3_out = mix_bus[3*W +: W];

	// Output stage per channel: switch, offset, DAC gain, monitor tap
	assign pid_bus = {pid3_in, pid2_in, pid1_in, pid0_in};
	generate
		for (g = 0; g < 4; g = g + 1) begin : och
			wire [1:0] mode;
			wire signed [39:0] swv;
			wire signed [39:0] ofv;
			wire signed [39:0] gained;
			reg signed [W-1:0] dac_q;
			reg signed [W-1:0] mon_q;
			assign mode = dac_mode[2*g +: 2];
			assign swv = ctrl[`PIM_CTRL_OUTSW_LSB+g] ? $signed(pid_bus[g*W +: W]) : $signed(40'h0);
			assign ofv = sat(swv + $signed(out_ofs[g]));
			assign gained = (mode == `PIM_DAC_14DB) ? sat(ofv * GAIN14) :
				(mode == `PIM_DAC_0DB) ? ofv : 40'h0;
			always @(posedge mclk_in) begin
				if (rst_in) begin
					dac_q <= {W{1'b0}};
					mon_q <= {W{1'b0}};
				end else if (ce_in && pid_valid_in) begin
					dac_q <= gained[W-1:0];
					if (ctrl[`PIM_CTRL_MON_LSB+g]) begin
						mon_q <= gained[W-1:0];
					end
				end
			end
			assign dac_bus[g*W +: W] = dac_q;
			assign mon_bus[g*W +: W] = mon_q;
			assign dac_en_out[g] = (mode == `PIM_DAC_0DB) || (mode == `PIM_DAC_14DB);
		end
	endgenerate

	assign dac0_out = dac_bus[0 +: W];
	assign dac1_out = dac_bus[W +: W];
	assign dac2_out = dac_bus[2*W +: W];
	assign dac3_out = dac_bus[3*W +: W];
	assign mon0_out = mon_bus[0 +: W];
	assign mon1_out = mon_bus[W +: W];
	assign mon2_out = mon_bus[2*W +: W];
	assign mon3_out = mon_bus[3*W +: W];

	// Output and monitor valids follow each accepted PID result
	always @(posedge mclk_in) begin
		if (rst_in) begin
			dac_valid_out <= 1'b0;
			mon_valid_out <= 4'h0;
		end else if (ce_in) begin
			dac_valid_out <= pid_valid_in;
			mon_valid_out <= pid_valid_in ? ctrl[`PIM_CTRL_MON_LSB +: 4] : 4'h0;
		end
	end

	// Word index inside the offset and coefficient windows
	assign aligned = (reg_addr_in[1:0] == 2'h0);
	assign word_idx = {2'h0, reg_addr_in[7:2]};
	assign level_ext = {{(31-FIFO_AW){1'b0}}, fifo_count}; // Level widened to a full word

	// Register writes; saturation flags set wins over a software clear
	always @(posedge mclk_in) begin
		if (rst_in) begin
			ctrl <= `PIM_CTRL_RST;
			dac_mode <= `PIM_DAC_RST;
			sat_sticky <= 4'h0;
			for (k = 0; k < 4; k = k + 1) begin
				in_ofs[k] <= `PIM_OFS_RST;
				out_ofs[k] <= `PIM_OFS_RST;
			end
			for (k = 0; k < 8; k = k + 1) begin
				coef[k] <= (k % 4 == 0 || k % 4 == 3) ? `PIM_COEF_ONE : `PIM_COEF_ZERO;
			end
		end else if (ce_in) begin
			if (reg_wr_in && aligned) begin
				if (reg_addr_in == `PIM_ADDR_CTRL) begin
					ctrl <= reg_wdata_in[11:0];
				end else if (reg_addr_in == `PIM_ADDR_DAC) begin
					dac_mode <= reg_wdata_in[7:0];
				end else if (reg_addr_in >= `PIM_ADDR_INOFS &&
					reg_addr_in < `PIM_ADDR_OUTOFS) begin
					in_ofs[word_idx[1:0] + 2'h2] <= reg_wdata_in[15:0];
				end else if (reg_addr_in >= `PIM_ADDR_OUTOFS &&
					reg_addr_in < `PIM_ADDR_COEF) begin
					out_ofs[word_idx[1:0] + 2'h2] <= reg_wdata_in[15:0];
				end else if (reg_addr_in >= `PIM_ADDR_COEF &&
					reg_addr_in <= `PIM_ADDR_COEF_LAST) begin
					coef[word_idx[2:0] + 3'h6] <= coef_fix(reg_wdata_in[15:0]);
				end
			end
			sat_sticky <= (sat_sticky & ~((reg_wr_in && aligned &&
				reg_addr_in == `PIM_ADDR_STATUS) ? reg_wdata_in[11:8] : 4'h0))
				| sat_pulse;
		end
	end

	// Read multiplexer; unmapped or unaligned reads return zero
	always @* begin
		next_rdata = 32'h00000000;
		if (!aligned) begin
			next_rdata = 32'h00000000;
		end else if (reg_addr_in == `PIM_ADDR_CTRL) begin
			next_rdata[11:0] = ctrl;
		end else if (reg_addr_in == `PIM_ADDR_DAC) begin
			next_rdata[7:0] = dac_mode;
		end else if (reg_addr_in >= `PIM_ADDR_INOFS && reg_addr_in < `PIM_ADDR_OUTOFS) begin
			next_rdata[15:0] = in_ofs[word_idx[1:0] + 2'h2];
			next_rdata[31:16] = {16{next_rdata[15]}};
		end else if (reg_addr_in >= `PIM_ADDR_OUTOFS && reg_addr_in < `PIM_ADDR_COEF) begin
			next_rdata[15:0] = out_ofs[word_idx[1:0] + 2'h2];
			next_rdata[31:16] = {16{next_rdata[15]}};
		end else if (reg_addr_in >= `PIM_ADDR_COEF && reg_addr_in <= `PIM_ADDR_COEF_LAST) begin
			next_rdata[15:0] = coef[word_idx[2:0] + 3'h6];
			next_rdata[31:16] = {16{next_rdata[15]}};
		end else if (reg_addr_in == `PIM_ADDR_STATUS) begin
			next_rdata[`PIM_ST_LEVEL_LSB +: 5] = level_ext[4:0];
			next_rdata[`PIM_ST_FULL_BIT] = !in_ready_out;
			next_rdata[`PIM_ST_EMPTY_BIT] = !fifo_valid;
			next_rdata[`PIM_ST_SAT_LSB +: 4] = sat_sticky;
		end
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge mclk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (ce_in) begin
			reg_rdata_out <= reg_rd_in ? next_rdata : 32'h00000000;
		end
	end
endmodule // pim_path
`default_nettype wire

// >>> tb/pim_path_monitor.sv
// Checker of the mixing path port timing
`timescale 1ns/100ps
`default_nettype none
module pim_path_monitor #(
	parameter W = 16
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic in_valid_in,
	input wire logic in_ready_out,
	input wire logic signed [W-1:0] mix0_out,
	input wire logic mix_valid_out,
	input wire logic mix_ready_in,
	input wire logic pid_valid_in,
	input wire logic signed [W-1:0] dac0_out,
	input wire logic [3:0] dac_en_out,
	input wire logic dac_valid_out,
	input wire logic signed [W-1:0] mon0_out,
	input wire logic [3:0] mon_valid_out
);
	// All checks on the sample clock, idle during reset
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	chk_dac_answer: assert property (pid_valid_in && ce_in |=> dac_valid_out)
		else $error("dac sample missing after pid result");
	chk_dac_off_zero: assert property (dac_valid_out && !dac_en_out[0] |-> dac0_out == 0)
		else $error("disabled dac stage not zero");
	chk_mon_copy: assert property (mon_valid_out[0] |-> dac_valid_out && mon0_out == dac0_out)
		else $error("monitor tap differs from output");
	chk_mon_gated: assert property (!dac_valid_out |-> mon_valid_out == 4'h0)
		else $error("monitor valid without output sample");
	chk_mix_hold: assert property (mix_valid_out && !mix_ready_in && ce_in |=> mix_valid_out && $stable(mix0_out))
		else $error("mixed sample dropped before acceptance");
	chk_mix_answer: assert property (in_valid_in && in_ready_out && ce_in |-> ##[2:200] mix_valid_out)
		else $error("taken sample never reached mix output");
	chk_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside its cycle");
	chk_reset_clear: assert property ($fell(rst_in) |-> in_ready_out && !mix_valid_out && dac_en_out == 4'h0)
		else $error("outputs not cleared by reset");
endmodule // pim_path_monitor
bind pim_path pim_path_monitor #(.W(W)) u_mon (.mclk_in, .rst_in, .ce_in, .reg_rd_in, .reg_rdata_out,
	.in_valid_in, .in_ready_out, .mix0_out, .mix_valid_out, .mix_ready_in, .pid_valid_in,
	.dac0_out, .dac_en_out, .dac_valid_out, .mon0_out, .mon_valid_out);
`default_nettype wire

// >>> tb/pim_path_tb.sv
// Self-checking bench of the mixing signal path
`timescale 1ns/100ps
`default_nettype none
module pim_path_tb;
	logic mclk = 1'b0;
	logic rst, ce, wr, rd, rd_d, in_valid, hold, mix_valid, mix_ready, pid_valid, dac_valid, ok;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, ctl, dm;
	logic [3:0] dac_en, mon_valid;
	logic [63:0] pid, e;
	logic signed [15:0] xin [4], mx [4], dc [4], mn [4];
	int io [4], oo [4], cf [8], failures, num_checks, k;
	int tv [8] = '{250, -250, 157, -157, 95, -95, 100, -3};
	logic [63:0] rq [$], mq [$], dq [$];
	wire ok_w;
	pim_path u_dut (.mclk_in(mclk), .rst_in(rst), .ce_in(ce), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.in0_in(xin[0]), .in1_in(xin[1]), .in2_in(xin[2]), .in3_in(xin[3]),
		.in_valid_in(in_valid), .in_ready_out(ok_w), .mix0_out(mx[0]), .mix1_out(mx[1]),
		.mix2_out(mx[2]), .mix3_out(mx[3]), .mix_valid_out(mix_valid), .mix_ready_in(mix_ready),
		.pid0_in(pid[15:0]), .pid1_in(pid[31:16]), .pid2_in(pid[47:32]), .pid3_in(pid[63:48]),
		.pid_valid_in(pid_valid), .dac0_out(dc[0]), .dac1_out(dc[1]), .dac2_out(dc[2]),
		.dac3_out(dc[3]), .dac_en_out(dac_en), .dac_valid_out(dac_valid), .mon0_out(mn[0]),
		.mon1_out(mn[1]), .mon2_out(mn[2]), .mon3_out(mn[3]), .mon_valid_out(mon_valid));
	pim_pid_model u_pid (.clk_in(mclk), .rst_in(rst), .hold_in(hold), .mix_valid_in(mix_valid),
		.mix_in({mx[3], mx[2], mx[1], mx[0]}), .mix_ready_out(mix_ready), .pid_out(pid),
		.pid_valid_out(pid_valid));
	// Clock
	always #2.5 mclk = ~mclk;
	function automatic int sat(int v);
		return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
	endfunction
	function automatic int snap(int v);
		int r;
		r = v > 200 ? 200 : (v < -200 ? -200 : v);
		return (r >= 100 || r <= -100) ? r / 10 * 10 : r;
	endfunction
	function automatic logic [63:0] dexp(logic [63:0] m);
		int y;
		for (int i = 0; i < 4; i++) begin
			y = sat((ctl[4+i] ? int'($signed(m[16*i+:16])) : 0) + oo[i]);
			y = dm[2*i+:2] == 2'h1 ? y : (dm[2*i+:2] == 2'h2 ? sat(y * 5) : 0);
			dexp[16*i+:16] = y[15:0];
		end
	endfunction
	// Lane mask of enabled monitor taps
	function automatic logic [63:0] msk(logic [3:0] m);
		for (int i = 0; i < 4; i++) msk[16*i+:16] = {16{m[i]}};
	endfunction
	// Output stage enabled for 0 dB and 14 dB only
	function automatic logic [3:0] enx(logic [31:0] d);
		for (int i = 0; i < 4; i++) enx[i] = d[2*i+:2] == 2'h1 || d[2*i+:2] == 2'h2;
	endfunction
	task automatic note(input logic [63:0] got, input logic [63:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		note(got, exp, "register read");
	endtask
	task automatic chk_mix(input logic [63:0] got, input logic [63:0] exp);
		note(got, exp, "mixed paths");
	endtask
	task automatic chk_dac(input logic [63:0] got, input logic [63:0] exp);
		note(got, exp, "dac samples");
	endtask
	task automatic chk_mon(input logic [63:0] got, input logic [63:0] exp);
		note(got, exp, "monitor taps");
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		rq.push_back({m, d});
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
	endtask
	// One sample on all four inputs, expectation noted first
	task automatic send(input int sh);
		logic signed [15:0] r;
		int s [4];
		int u [4];
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			xin[i] <= r >>> sh;
			s[i] = sat((ctl[i] ? int'(r >>> sh) : 0) + io[i]);
		end
		for (int g = 0; g < 2; g++) begin
			u[2*g] = sat((s[2*g] * cf[4*g] + s[2*g+1] * cf[4*g+1]) / 10);
			u[2*g+1] = sat((s[2*g] * cf[4*g+2] + s[2*g+1] * cf[4*g+3]) / 10);
		end
		mq.push_back({u[3][15:0], u[2][15:0], u[1][15:0], u[0][15:0]});
		in_valid <= 1'b1;
		do begin
			@(negedge mclk);
			ok = ok_w;
			@(posedge mclk);
		end while (!ok);
	endtask
	task automatic drain();
		k = 0;
		while ((mq.size() || dq.size()) && k < 500) begin
			@(posedge mclk);
			k++;
		end
		if (mq.size() || dq.size()) begin
			failures++;
			$display("CHECK FAILED %0t results missing after drain", $time);
		end
	endtask
	// Results are compared where they stand settled
	always @(posedge mclk) rd_d <= rd;
	always @(negedge mclk) begin
		if (rd_d) begin
			e = rq.size() ? rq.pop_front() : 'x;
			chk_rd(rdata & e[63:32], e[31:0]);
		end
		if (mix_valid && mix_ready) begin
			e = mq.size() ? mq.pop_front() : 'x;
			chk_mix({mx[3], mx[2], mx[1], mx[0]}, e);
			dq.push_back(dexp(e));
		end
		if (dac_valid) begin
			e = dq.size() ? dq.pop_front() : 'x;
			chk_dac({dc[3], dc[2], dc[1], dc[0]}, e);
			chk_dac({60'h0, dac_en}, {60'h0, enx(dm)});
			chk_mon({mn[3], mn[2], mn[1], mn[0]} & msk(ctl[11:8]), e & msk(ctl[11:8]));
			chk_mon({60'h0, mon_valid}, {60'h0, ctl[11:8]});
		end
	end
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#(5.0 * 20000);
		failures++;
		final_report();
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		{wr, rd, in_valid, hold, addr, wdata} = '0;
		ce = 1'b1;
		xin = '{default: 16'h0};
		void'($urandom(44846));
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(8'h00, 32'h0, 32'hFFFFFFFF);
		rd_reg(8'h28, 32'hA, 32'hFFFFFFFF);
		rd_reg(8'h2C, 32'h0, 32'hFFFFFFFF);
		rd_reg(8'h48, 32'h40, 32'h7F);
		wr_reg(8'h4C, 32'hFFFF);
		rd_reg(8'h4C, 32'h0, 32'hFFFFFFFF);
		rd_reg(8'h29, 32'h0, 32'hFFFFFFFF);
		foreach (cf[i]) begin
			k = tv[i];
			wr_reg(8'h28 + 8'(4 * i), k);
			rd_reg(8'h28 + 8'(4 * i), snap(k), 32'hFFFFFFFF);
		end
		for (int p = 0; p < 4; p++) begin
			ctl = (p == 1) ? 32'hFFF : ($urandom & 32'hFFF);
			dm = 32'h55 * p;
			wr_reg(8'h00, ctl);
			wr_reg(8'h04, dm);
			for (int i = 0; i < 4; i++) begin
				io[i] = $signed(16'($urandom)) >>> (p[0] ? 0 : 6);
				oo[i] = $signed(16'($urandom)) >>> 4;
				wr_reg(8'h08 + 8'(4 * i), io[i]);
				wr_reg(8'h18 + 8'(4 * i), oo[i]);
			end
			foreach (cf[i]) begin
				k = int'($urandom % 441) - 220;
				cf[i] = snap(k);
				wr_reg(8'h28 + 8'(4 * i), k);
			end
			rd_reg(8'h00, ctl, 32'hFFFFFFFF);
			@(posedge mclk);
			repeat (20) send(p[0] ? 0 : 4);
			in_valid <= 1'b0;
			drain();
		end
		// Clock enable low: a write in this window must not land
		ce <= 1'b0;
		wr_reg(8'h00, ~ctl);
		ce <= 1'b1;
		rd_reg(8'h00, ctl, 32'hFFFFFFFF);
		hold <= 1'b1;
		fork
			begin
				@(posedge mclk);
				repeat (20) send(2);
				in_valid <= 1'b0;
			end
			begin
				k = 0;
				do @(negedge mclk); while (ok_w && ++k < 100);
				rd_reg(8'h48, 32'h30, 32'h7F);
				hold <= 1'b0;
			end
		join
		drain();
		rd_reg(8'h48, 32'h40, 32'h7F);
		repeat (4) @(posedge mclk);
		final_report();
	end
endmodule // pim_path_tb
`default_nettype wire

// >>> tb/pim_pid_model.sv
// Controller side model: accepts mixed samples and returns them as results
`timescale 1ns/100ps
`default_nettype none
module pim_pid_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic hold_in,
	input wire logic mix_valid_in,
	input wire logic [63:0] mix_in,
	output logic mix_ready_out,
	output logic [63:0] pid_out,
	output logic pid_valid_out
);
	// Random stalls, unity controller, channel N result from mixed path N
	always @(posedge clk_in) begin
		if (rst_in) begin
			mix_ready_out <= 1'b0;
			pid_valid_out <= 1'b0;
			pid_out <= 64'h0;
		end else begin
			mix_ready_out <= !hold_in && ($urandom % 4 != 0);
			pid_valid_out <= mix_valid_in && mix_ready_out;
			pid_out <= (mix_valid_in && mix_ready_out) ? mix_in : ~pid_out;
		end
	end
endmodule // pim_pid_model
`default_nettype wire
